// File: logic/wdtu_consts.svh
// offsets, field positions and reset values of the watchdog timer unit
`ifndef WDTU_CONSTS_SVH
`define WDTU_CONSTS_SVH

// ------------------------------------------------------------
// register byte offsets
// ------------------------------------------------------------
`define WDTU_OFS_CONTROL   12'h80C
`define WDTU_OFS_STATUS    12'h810
`define WDTU_OFS_MASK      12'h814
`define WDTU_OFS_CONFIG    12'h818
`define WDTU_OFS_COUNT     12'h81C

// ------------------------------------------------------------
// field positions
// ------------------------------------------------------------
`define WDTU_CTL_CS_BIT    7
`define WDTU_CTL_PS_MSB    5
`define WDTU_CTL_PS_LSB    1
`define WDTU_CTL_SEN_BIT   0
`define WDTU_ST_RESET_BIT  0
`define WDTU_ST_WAKE_BIT   1

// ------------------------------------------------------------
// reset values and limits
// ------------------------------------------------------------
`define WDTU_PS_RESET      5'h0B
`define WDTU_PS_MAX        5'h12
`define WDTU_MODE_RESET    2'h3
`define WDTU_MIN_RATIO_LOG 5
`define WDTU_CNT_WIDTH     23

`endif

// File: logic/wdtu_pkg.sv
// types of the watchdog timer unit
package wdtu_pkg;

   // ---------------------------------------------------------
   // watchdog mode configuration
   // ---------------------------------------------------------
   typedef enum logic [1:0]
   {
      WDTU_MODE_OFF,
      WDTU_MODE_SOFT,
      WDTU_MODE_AWAKE,
      WDTU_MODE_ON
   } wdtu_mode_type;

   // ---------------------------------------------------------
   // clock source select
   // ---------------------------------------------------------
   typedef enum logic
   {
      WDTU_SRC_LOW,
      WDTU_SRC_MID
   } wdtu_src_type;

endpackage : wdtu_pkg

// File: logic/wdtu_top.sv
// watchdog timer unit with apb register slave
//
// Function
// - timeout while active and awake requests reset
// - cs bit picks mid or low oscillator
// - mode 11 always active, sleep too
// - mode 10 active awake, off asleep
// - mode 01 follows software enable bit
// - mode 00 always disabled
// - ratio is 32 times two to code
// - codes 10011 to 11111 give 1:32
// - prescale code resets to 01011
// - count clears on reset, clear, sleep edges
// - any control write clears the count
// - count restarts and runs through sleep, except in mode 10
// - sleep timeout wakes, clears status flags
//
// Design decision made here: the APB register port.
`include "wdtu_consts.svh"

module wdtu_top
#(
   parameter int CNT_WIDTH = `WDTU_CNT_WIDTH
)
(
   input  wire logic        clk_in,
   input  wire logic        rst_in,
   input  wire logic        psel_in,
   input  wire logic        penable_in,
   input  wire logic        pwrite_in,
   input  wire logic [11:0] paddr_in,
   input  wire logic [31:0] pwdata_in,
   output logic      [31:0] prdata_out,
   output logic             pready_out,
   output logic             pslverr_out,
   input  wire logic        mid_freq_internal_osc_in,
   input  wire logic        low_freq_internal_osc_in,
   input  wire logic        clear_watchdog_instruction_in,
   input  wire logic        sleep_in,
   output logic             reset_request_out,
   output logic             wake_out,
   output logic             status_flags_clear_out,
   output logic             irq_out
);

   // ---------------------------------------------------------
   // elaboration checks
   // ---------------------------------------------------------
   // a narrower count cannot hold the longest ratio
   if (CNT_WIDTH < `WDTU_CNT_WIDTH)
   begin : g_narrow
      $error("wdtu_top: CNT_WIDTH too small for the longest ratio");
   end
   // the count reads back through a single 32-bit word
   if (CNT_WIDTH > 32)
   begin : g_wide
      $error("wdtu_top: CNT_WIDTH wider than the data bus");
   end

   // ---------------------------------------------------------
   // terminal count of the selected ratio
   // ---------------------------------------------------------
   function automatic logic [CNT_WIDTH-1:0] term_count
   (
      input logic [4:0] code
   );
      logic [4:0] eff;
      logic [4:0] shift;
      eff = (code > `WDTU_PS_MAX) ? 5'h00 : code;
      shift = eff + 5'(`WDTU_MIN_RATIO_LOG);
      term_count = (CNT_WIDTH'(1) << shift) - CNT_WIDTH'(1);
   endfunction : term_count

   // ---------------------------------------------------------
   // settled level of a three-stage synchroniser
   // ---------------------------------------------------------
   function automatic logic settle
   (
      input logic [2:0] stages,
      input logic       held
   );
      settle = (stages[1] == stages[2]) ? stages[2] : held;
   endfunction : settle

   // ---------------------------------------------------------
   // registers
   // ---------------------------------------------------------
   logic                  cs_q;
   logic [4:0]            ps_q;
   logic                  sen_q;
   logic [1:0]            mode_q;
   logic [1:0]            status_q;
   logic [1:0]            status_d;
   logic [1:0]            mask_q;
   logic [CNT_WIDTH-1:0]  count_q;
   logic [CNT_WIDTH-1:0]  count_d;
   logic                  sleep_q;
   logic [31:0]           prdata_q;
   logic                  reset_req_q;
   logic                  wake_q;
   logic                  flags_clr_q;

   // ---------------------------------------------------------
   // oscillator synchronisers, three stages each
   // ---------------------------------------------------------
   logic [2:0]            mid_sync_q;
   logic [2:0]            low_sync_q;
   logic                  mid_lvl_q;
   logic                  low_lvl_q;
   logic                  mid_lvl_d;
   logic                  low_lvl_d;
   wire logic             mid_rise;
   wire logic             low_rise;
   wire logic             tick;

   // a level counts only once stages two and three agree
   assign mid_lvl_d = settle(mid_sync_q, mid_lvl_q);
   assign low_lvl_d = settle(low_sync_q, low_lvl_q);
   assign mid_rise  = mid_lvl_d & ~mid_lvl_q;
   assign low_rise  = low_lvl_d & ~low_lvl_q;
   assign tick      = (cs_q == wdtu_pkg::WDTU_SRC_MID) ?
                      mid_rise : low_rise;

   always_ff @(posedge clk_in or posedge rst_in)
   begin
      if (rst_in)
      begin
         mid_sync_q <= 3'h0;
         low_sync_q <= 3'h0;
         mid_lvl_q  <= 1'b0;
         low_lvl_q  <= 1'b0;
      end
      else
      begin
         mid_sync_q <= {mid_sync_q[1:0], mid_freq_internal_osc_in};
         low_sync_q <= {low_sync_q[1:0], low_freq_internal_osc_in};
         mid_lvl_q  <= mid_lvl_d;
         low_lvl_q  <= low_lvl_d;
      end
   end

   // ---------------------------------------------------------
   // apb decode
   // ---------------------------------------------------------
   wire logic             setup;
   wire logic             access;
   wire logic             hit_ctl;
   wire logic             hit_st;
   wire logic             hit_mask;
   wire logic             hit_cfg;
   wire logic             hit_cnt;
   wire logic             hit_any;
   wire logic             wr_ctl;
   wire logic             wr_mask;
   wire logic             wr_cfg;
   wire logic             rd_st;
   logic [31:0]           rd_mux;

   assign setup    = psel_in & ~penable_in;
   assign access   = psel_in & penable_in;
   assign hit_ctl  = (paddr_in == `WDTU_OFS_CONTROL);
   assign hit_st   = (paddr_in == `WDTU_OFS_STATUS);
   assign hit_mask = (paddr_in == `WDTU_OFS_MASK);
   assign hit_cfg  = (paddr_in == `WDTU_OFS_CONFIG);
   assign hit_cnt  = (paddr_in == `WDTU_OFS_COUNT);
   assign hit_any  = hit_ctl | hit_st | hit_mask | hit_cfg | hit_cnt;
   assign wr_ctl   = access & pwrite_in & hit_ctl;
   assign wr_mask  = access & pwrite_in & hit_mask;
   assign wr_cfg   = access & pwrite_in & hit_cfg;
   assign rd_st    = access & ~pwrite_in & hit_st;

   always_comb
   begin
      rd_mux = 32'h0000_0000;
      if (hit_ctl)
      begin
         rd_mux = {24'h00_0000, cs_q, 1'b0, ps_q, sen_q};
      end
      else if (hit_st)
      begin
         rd_mux = {30'h0000_0000, status_q};
      end
      else if (hit_mask)
      begin
         rd_mux = {30'h0000_0000, mask_q};
      end
      else if (hit_cfg)
      begin
         rd_mux = {30'h0000_0000, mode_q};
      end
      else if (hit_cnt)
      begin
         rd_mux = 32'(count_q);
      end
   end

   // read data is captured in setup so it leaves a flip-flop
   assign prdata_out  = prdata_q;
   assign pready_out  = access;
   // an unmapped access still answers, with the error flag set
   assign pslverr_out = access & ~hit_any;

   // ---------------------------------------------------------
   // watchdog activity and count
   // ---------------------------------------------------------
   wdtu_pkg::wdtu_mode_type mode;
   logic                  active;
   wire logic             sleep_edge;
   wire logic             expire;
   wire logic             clear_cnt;
   wire logic             awake_expire;
   wire logic             sleep_expire;
   logic [CNT_WIDTH-1:0]  term;

   assign mode = wdtu_pkg::wdtu_mode_type'(mode_q);

   always_comb
   begin
      case (mode)
         wdtu_pkg::WDTU_MODE_ON:    active = 1'b1;
         wdtu_pkg::WDTU_MODE_AWAKE: active = ~sleep_in;
         wdtu_pkg::WDTU_MODE_SOFT:  active = sen_q;
         default:                   active = 1'b0;
      endcase
   end

   // sleep_q resets awake, so a reset taken asleep clears once more
   assign sleep_edge = sleep_in ^ sleep_q;
   // clear on instruction, on sleep entry and exit, on control write
   assign clear_cnt  = clear_watchdog_instruction_in | sleep_edge
                       | wr_ctl;
   // reserved codes are stored as written and only act as 1:32
   assign term       = term_count(ps_q);
   // a clear in the expiring cycle wins, so a late clear still rescues
   assign expire     = active & ~clear_cnt & tick
                       & (count_q == term);
   assign awake_expire = expire & ~sleep_in;
   assign sleep_expire = expire & sleep_in;

   always_comb
   begin
      count_d = count_q;
      if (~active | clear_cnt | expire)
      begin
         count_d = '0;
      end
      else if (tick)
      begin
         count_d = count_q + CNT_WIDTH'(1);
      end
   end

   // ---------------------------------------------------------
   // sticky status, set wins over read clear
   // ---------------------------------------------------------
   wire logic [1:0]       events;

   assign events[`WDTU_ST_RESET_BIT] = awake_expire;
   assign events[`WDTU_ST_WAKE_BIT]  = sleep_expire;
   assign status_d = (rd_st ? 2'h0 : status_q) | events;
   assign irq_out  = |(status_q & mask_q);

   // ---------------------------------------------------------
   // state and control registers
   // ---------------------------------------------------------
   always_ff @(posedge clk_in or posedge rst_in)
   begin
      if (rst_in)
      begin
         cs_q     <= 1'b0;
         ps_q     <= `WDTU_PS_RESET;
         sen_q    <= 1'b0;
         mode_q   <= `WDTU_MODE_RESET;
         mask_q   <= 2'h0;
         prdata_q <= 32'h0000_0000;
      end
      else
      begin
         if (wr_ctl)
         begin
            cs_q  <= pwdata_in[`WDTU_CTL_CS_BIT];
            ps_q  <= pwdata_in[`WDTU_CTL_PS_MSB:`WDTU_CTL_PS_LSB];
            sen_q <= pwdata_in[`WDTU_CTL_SEN_BIT];
         end
         if (wr_mask)
         begin
            mask_q <= pwdata_in[1:0];
         end
         if (wr_cfg)
         begin
            mode_q <= pwdata_in[1:0];
         end
         if (setup)
         begin
            prdata_q <= rd_mux;
         end
      end
   end

   // ---------------------------------------------------------
   // count, status and sleep history
   // ---------------------------------------------------------
   always_ff @(posedge clk_in or posedge rst_in)
   begin
      if (rst_in)
      begin
         status_q <= 2'h0;
         count_q  <= '0;
         sleep_q  <= 1'b0;
      end
      else
      begin
         status_q <= status_d;
         count_q  <= count_d;
         sleep_q  <= sleep_in;
      end
   end

   // ---------------------------------------------------------
   // timeout outputs, one-cycle pulses
   // ---------------------------------------------------------
   always_ff @(posedge clk_in or posedge rst_in)
   begin
      if (rst_in)
      begin
         reset_req_q <= 1'b0;
         wake_q      <= 1'b0;
         flags_clr_q <= 1'b0;
      end
      else
      begin
         // a timeout asleep wakes and clears status flags; it must never reset the core
         reset_req_q <= awake_expire;
         wake_q      <= sleep_expire;
         flags_clr_q <= sleep_expire;
      end
   end

   assign reset_request_out      = reset_req_q;
   assign wake_out               = wake_q;
   assign status_flags_clear_out = flags_clr_q;

endmodule : wdtu_top

// File: test/wdtu_top_properties.sv
// port assertions of the watchdog timer unit
`include "wdtu_consts.svh"
module wdtu_props
(
   input wire logic        clk_in,
   input wire logic        rst_in,
   input wire logic        psel_in,
   input wire logic        penable_in,
   input wire logic        pwrite_in,
   input wire logic [11:0] paddr_in,
   input wire logic [31:0] prdata_out,
   input wire logic        pready_out,
   input wire logic        pslverr_out,
   input wire logic        clear_watchdog_instruction_in,
   input wire logic        sleep_in,
   input wire logic        reset_request_out,
   input wire logic        wake_out,
   input wire logic        status_flags_clear_out,
   input wire logic        irq_out
);
   timeunit 1ns;
   timeprecision 1ns;
   default clocking dc @(posedge clk_in);
   endclocking
   default disable iff (rst_in);
   wire acc = psel_in && penable_in;
   wire unm = !(paddr_in inside {`WDTU_OFS_CONTROL, `WDTU_OFS_STATUS,
      `WDTU_OFS_MASK, `WDTU_OFS_CONFIG, `WDTU_OFS_COUNT});
   wire cwr = acc && pwrite_in && paddr_in == `WDTU_OFS_CONTROL;
   wire tmo = reset_request_out || wake_out;
   property p_rdy; pready_out == acc; endproperty
   a_rdy: assert property (p_rdy)
      else $error("bad pready");
   property p_err; acc |-> pslverr_out == unm; endproperty
   a_err: assert property (p_err)
      else $error("bad pslverr");
   property p_unrd; acc && unm && !pwrite_in |-> prdata_out == 32'h0;
   endproperty
   a_unrd: assert property (p_unrd)
      else $error("unmapped read not zero");
   property p_rr; reset_request_out |=> !reset_request_out; endproperty
   a_rr: assert property (p_rr)
      else $error("long reset request");
   property p_rrawk; reset_request_out |-> !$past(sleep_in); endproperty
   a_rrawk: assert property (p_rrawk)
      else $error("reset request while asleep");
   property p_wk;
      wake_out |-> $past(sleep_in) && status_flags_clear_out;
   endproperty
   a_wk: assert property (p_wk)
      else $error("bad wake pulse");
   property p_flg; status_flags_clear_out == wake_out; endproperty
   a_flg: assert property (p_flg)
      else $error("flag clear apart from wake");
   property p_clr; clear_watchdog_instruction_in |=> !tmo; endproperty
   a_clr: assert property (p_clr)
      else $error("timeout after clear");
   property p_cwr; cwr |=> !tmo; endproperty
   a_cwr: assert property (p_cwr)
      else $error("timeout after control write");
   c_rr: cover property (reset_request_out);
   c_wk: cover property (wake_out);
   c_irq: cover property (irq_out);
endmodule : wdtu_props

bind wdtu_top wdtu_props u_wdtu_props (.clk_in, .rst_in, .psel_in,
   .penable_in, .pwrite_in, .paddr_in, .prdata_out, .pready_out,
   .pslverr_out, .clear_watchdog_instruction_in, .sleep_in,
   .reset_request_out, .wake_out, .status_flags_clear_out, .irq_out);

// File: test/wdtu_core_model.sv
// processor-side model: oscillators and clear instructions
module wdtu_core_model
(
   input  wire logic clk_in,
   input  wire logic keep_in,
   output logic      mid_out,
   output logic      low_out,
   output logic      clr_out
);
   timeunit 1ns;
   timeprecision 1ns;
   logic [5:0] gap_q = 6'h00;
   // oscillators sped up to 8 and 12 clocks so runs stay short
   initial
   begin
      low_out = 1'b0;
      #7;
      forever #200 low_out = ~low_out;
   end
   initial
   begin
      mid_out = 1'b0;
      #11;
      forever #300 mid_out = ~mid_out;
   end
   // one-cycle clear every 64 clocks while kept alive
   always @(posedge clk_in)
      gap_q <= gap_q + 6'h01;
   assign clr_out = keep_in && gap_q == 6'h3F;
endmodule : wdtu_core_model

// File: test/tb.sv
// self-checking bench of the watchdog timer unit
`include "wdtu_consts.svh"
module tb;
   timeunit 1ns;
   timeprecision 1ns;
   logic        clk_in, rst_in, psel_in, penable_in, pwrite_in;
   logic        sleep_in, keep, perr, pready_out, pslverr_out, irq_out;
   logic        reset_request_out, wake_out, status_flags_clear_out;
   logic        mid_osc, low_osc, clr;
   logic [11:0] paddr_in;
   logic [31:0] pwdata_in, prdata_out, rd;
   int          fails, checks, cyc;

   wdtu_top u_wdtu_top (.clk_in, .rst_in, .psel_in, .penable_in,
      .pwrite_in, .paddr_in, .pwdata_in, .prdata_out, .pready_out,
      .pslverr_out, .mid_freq_internal_osc_in(mid_osc),
      .low_freq_internal_osc_in(low_osc),
      .clear_watchdog_instruction_in(clr), .sleep_in, .reset_request_out,
      .wake_out, .status_flags_clear_out, .irq_out);
   wdtu_core_model u_wdtu_core_model (.clk_in, .keep_in(keep),
      .mid_out(mid_osc), .low_out(low_osc), .clr_out(clr));

   task automatic close_out;
      $display("checks %0d fails %0d", checks, fails);
      if (fails == 0 && checks > 0)
         $display("ALL CHECKS OK");
      else
         $display("CHECKS NOT OK");
      $finish;
   endtask : close_out

   task automatic chk(input logic [31:0] g, input logic [31:0] e);
      checks++;
      if (g !== e)
      begin
         fails++;
         $display("MISMATCH %0t got %h want %h", $time, g, e);
      end
   endtask : chk

   task automatic apb(input logic w, input logic [11:0] a,
                      input logic [31:0] d);
      psel_in <= 1'b1;
      pwrite_in <= w;
      paddr_in <= a;
      pwdata_in <= d;
      @(posedge clk_in);
      penable_in <= 1'b1;
      // no wait-state count assumed; the hang guard ends a stuck wait
      do
      begin
         @(posedge clk_in);
      end
      while (pready_out !== 1'b1);
      rd = prdata_out;
      perr = pslverr_out;
      psel_in <= 1'b0;
      penable_in <= 1'b0;
      @(posedge clk_in);
   endtask : apb

   // window, reset request, wake, flag clear; t is clocks to expiry
   task automatic run(input logic [1:0] m, input logic [7:0] c,
                      input logic s, input int t, input logic [3:0] e);
      int n;
      sleep_in <= s;
      apb(1'b1, `WDTU_OFS_CONFIG, {30'h0, m});
      apb(1'b1, `WDTU_OFS_CONTROL, {24'h0, c});
      n = 0;
      while (n < 700 && (reset_request_out | wake_out) !== 1'b1)
      begin
         @(posedge clk_in);
         n++;
      end
      chk({28'h0, n > t - 20 && n < t + 10, reset_request_out, wake_out,
           status_flags_clear_out}, {28'h0, e});
   endtask : run

   task automatic t_reset;
      apb(1'b0, `WDTU_OFS_CONTROL, 32'h0);
      chk(rd, 32'h16);
      apb(1'b0, `WDTU_OFS_CONFIG, 32'h0);
      chk(rd, 32'h3);
      apb(1'b0, 12'h900, 32'h0);
      chk({rd[30:0], perr}, 32'h1);
   endtask : t_reset

   task automatic t_ratio;
      logic [7:0] c [5] = '{8'h00, 8'h02, 8'h26, 8'h3E, 8'h80};
      int t [5] = '{256, 512, 256, 256, 384};
      foreach (c[i])
         run(2'h3, c[i], 1'b0, t[i], 4'hC);
   endtask : t_ratio

   task automatic t_modes;
      run(2'h3, 8'h00, 1'b1, 256, 4'hB);
      run(2'h2, 8'h00, 1'b0, 256, 4'hC);
      run(2'h2, 8'h00, 1'b1, 256, 4'h0);
      run(2'h1, 8'h01, 1'b0, 256, 4'hC);
      run(2'h1, 8'h00, 1'b0, 256, 4'h0);
      run(2'h0, 8'h01, 1'b0, 256, 4'h0);
   endtask : t_modes

   task automatic t_clear;
      keep <= 1'b1;
      run(2'h3, 8'h00, 1'b0, 256, 4'h0);
      keep <= 1'b0;
   endtask : t_clear

   task automatic t_irq;
      apb(1'b1, `WDTU_OFS_MASK, 32'h0);
      apb(1'b0, `WDTU_OFS_STATUS, 32'h0);
      run(2'h3, 8'h00, 1'b0, 256, 4'hC);
      chk({31'h0, irq_out}, 32'h0);
      apb(1'b1, `WDTU_OFS_MASK, 32'h3);
      chk({31'h0, irq_out}, 32'h1);
      apb(1'b0, `WDTU_OFS_STATUS, 32'h0);
      chk(rd, 32'h1);
      chk({31'h0, irq_out}, 32'h0);
   endtask : t_irq

   // reset in mid-run while the count is running
   task automatic t_midreset;
      apb(1'b1, `WDTU_OFS_CONTROL, 32'h3F);
      repeat (40) @(posedge clk_in);
      apb(1'b0, `WDTU_OFS_COUNT, 32'h0);
      chk({31'h0, rd != 32'h0}, 32'h1);
      rst_in <= 1'b1;
      repeat (2) @(posedge clk_in);
      rst_in <= 1'b0;
      @(posedge clk_in);
      apb(1'b0, `WDTU_OFS_COUNT, 32'h0);
      chk(rd, 32'h0);
      apb(1'b0, `WDTU_OFS_CONTROL, 32'h0);
      chk(rd, 32'h16);
      apb(1'b0, `WDTU_OFS_CONFIG, 32'h0);
      chk(rd, 32'h3);
   endtask : t_midreset

   initial
   begin
      clk_in = 1'b0;
      forever #25 clk_in = ~clk_in;
   end

   initial
   begin
      rst_in = 1'b1;
      {psel_in, penable_in, pwrite_in, sleep_in, keep} = 5'h0;
      paddr_in = 12'h0;
      pwdata_in = 32'h0;
      repeat (6) @(posedge clk_in);
      rst_in <= 1'b0;
      @(posedge clk_in);
      t_reset();
      t_ratio();
      t_modes();
      t_clear();
      t_irq();
      t_midreset();
      close_out();
   end

   // hang guard, about twice the expected run
   always @(posedge clk_in)
   begin
      cyc++;
      if (cyc == 12000)
      begin
         fails++;
         close_out();
      end
   end
endmodule : tb
